// ===== mmd_map.svh
// address map and vector map for the memory map decoder
`ifndef MMD_MAP_SVH
`define MMD_MAP_SVH
`define MMD_ADDR_W 16
`define MMD_REG_TOP 16'h003f
`define MMD_RAM_TOP 16'h01ff
`define MMD_STACK_LO 16'h0100
`define MMD_STACK_HI 16'h017f
`define MMD_ROM_LO 16'hc000
`define MMD_VEC_LO 16'hffe0
`define MMD_VEC_RES_HI 16'hffed
`define MMD_PORT_LO 16'h0000
`define MMD_PORT_HI 16'h0005
`define MMD_EXTI_ADDR 16'h0008
`define MMD_MISC_ADDR 16'h0009
`define MMD_CONV_DATA_ADDR 16'h000a
`define MMD_CONV_CSR_ADDR 16'h000b
`define MMD_WDOG_ADDR 16'h000c
`define MMD_TIMER_LO 16'h0011
`define MMD_TIMER_HI 16'h001f
`define MMD_SERIAL_LO 16'h0020
`define MMD_SERIAL_HI 16'h0024
`define MMD_VEC_LINK 16'hffee
`define MMD_VEC_SERIAL 16'hfff0
`define MMD_VEC_TWI 16'hfff2
`define MMD_VEC_TIMER 16'hfff4
`define MMD_VEC_EXT 16'hfff6
`define MMD_VEC_RESUME 16'hfff8
`define MMD_VEC_PROG 16'hfffa
`define MMD_VEC_TRAP 16'hfffc
`define MMD_VEC_RESET 16'hfffe
`define MMD_NUM_SRC 9
`endif

// ===== mmd_pkg.sv
// types shared by the memory map decoder
package mmd_pkg;
	// region selected by an address
	typedef enum logic [3:0] {
		MMD_RGN_NONE = 4'h0,
		MMD_RGN_PORT = 4'h1,
		MMD_RGN_EXTI = 4'h2,
		MMD_RGN_MISC = 4'h3,
		MMD_RGN_CONV = 4'h4,
		MMD_RGN_WDOG = 4'h5,
		MMD_RGN_TIMER = 4'h6,
		MMD_RGN_SERIAL = 4'h7,
		MMD_RGN_UPPER = 4'h8,
		MMD_RGN_RAM = 4'h9,
		MMD_RGN_STACK = 4'ha,
		MMD_RGN_ROM = 4'hb,
		MMD_RGN_VECTOR = 4'hc,
		MMD_RGN_RSVD = 4'hd
	} mmd_region_e;
	// vector fetch sequencer, gray along idle, low, high
	typedef enum logic [1:0] {
		MMD_VS_IDLE = 2'b00,
		MMD_VS_LOW = 2'b01,
		MMD_VS_HIGH = 2'b11
	} mmd_vstate_e;
	typedef logic [15:0] mmd_addr_t;
endpackage

// ===== mmd_vec_select.sv
// interrupt source to vector selector with mask and halt wake attributes
`timescale 1ns/1ps
`include "mmd_map.svh"
module mmd_vec_select (
	input wire logic [`MMD_NUM_SRC-1:0] src_req,
	input wire logic global_mask,
	output logic any_take,
	output logic [15:0] vec_addr,
	output logic wake
);
	// source order is priority order: reset, trap, prog, resume, ext, timer, twi, serial, link
	localparam logic [15:0] VEC [`MMD_NUM_SRC] = '{`MMD_VEC_RESET, `MMD_VEC_TRAP,
		`MMD_VEC_PROG, `MMD_VEC_RESUME, `MMD_VEC_EXT, `MMD_VEC_TIMER, `MMD_VEC_TWI,
		`MMD_VEC_SERIAL, `MMD_VEC_LINK};
	// every source from prog at bit 2 upward obeys the mask, the link source at bit 8 too
	localparam logic [`MMD_NUM_SRC-1:0] MASKABLE = 9'h1fc;
	localparam logic [`MMD_NUM_SRC-1:0] WAKES = 9'h01d;
	logic [`MMD_NUM_SRC-1:0] eff;
	genvar g;
	// reset and trap ignore the mask; all others obey it
	generate
		for (g = 0; g < `MMD_NUM_SRC; g++) begin : g_eff
			assign eff[g] = src_req[g] & ~(MASKABLE[g] & global_mask);
		end
	endgenerate
	// lowest index wins
	always_comb begin
		any_take = 1'b0;
		vec_addr = VEC[0];
		wake = 1'b0;
		for (int i = `MMD_NUM_SRC - 1; i >= 0; i--) begin
			if (eff[i]) begin
				any_take = 1'b1;
				vec_addr = VEC[i];
				wake = WAKES[i];
			end
		end
	end
endmodule

// ===== mmd_decoder.sv
// memory map decoder with vector fetch sequencing
`timescale 1ns/1ps
`include "mmd_map.svh"
module mmd_decoder (
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic [15:0] cpu_addr,
	input wire logic cpu_access,
	input wire logic [`MMD_NUM_SRC-1:0] irq_src,
	input wire logic global_mask,
	input wire logic halted,
	input wire logic vec_ack,
	output logic [3:0] region_q,
	output logic [4:0] reg_index_q,
	output logic ram_sel_q,
	output logic stack_sel_q,
	output logic reg_sel_q,
	output logic rom_sel_q,
	output logic rsvd_hit_q,
	output logic [6:0] periph_sel_q,
	output logic [15:0] vec_fetch_addr_q,
	output logic vec_fetch_valid_q,
	output logic vec_fetch_last_q,
	output logic halt_exit_q
);
	mmd_pkg::mmd_region_e rgn_d;
	logic [4:0] idx_d;
	logic take;
	logic [15:0] sel_vec;
	logic sel_wake;
	mmd_pkg::mmd_vstate_e vs_q;
	logic [15:0] vec_base_q;

	mmd_vec_select u_sel (
		.src_req(irq_src),
		.global_mask(global_mask),
		.any_take(take),
		.vec_addr(sel_vec),
		.wake(sel_wake)
	);

	// address decode; upper register page is passed on as one region
	always_comb begin
		rgn_d = mmd_pkg::MMD_RGN_NONE;
		idx_d = 5'h00;
		if (cpu_addr <= `MMD_PORT_HI) begin
			rgn_d = mmd_pkg::MMD_RGN_PORT;
			idx_d = cpu_addr[4:0];
		end else if (cpu_addr < `MMD_EXTI_ADDR) begin
			rgn_d = mmd_pkg::MMD_RGN_RSVD;
		end else if (cpu_addr == `MMD_EXTI_ADDR) begin
			rgn_d = mmd_pkg::MMD_RGN_EXTI;
		end else if (cpu_addr == `MMD_MISC_ADDR) begin
			rgn_d = mmd_pkg::MMD_RGN_MISC;
		end else if (cpu_addr == `MMD_CONV_DATA_ADDR || cpu_addr == `MMD_CONV_CSR_ADDR) begin
			rgn_d = mmd_pkg::MMD_RGN_CONV;
			idx_d = 5'(cpu_addr - `MMD_CONV_DATA_ADDR);
		end else if (cpu_addr == `MMD_WDOG_ADDR) begin
			rgn_d = mmd_pkg::MMD_RGN_WDOG;
		end else if (cpu_addr < `MMD_TIMER_LO) begin
			rgn_d = mmd_pkg::MMD_RGN_RSVD;
		end else if (cpu_addr <= `MMD_TIMER_HI) begin
			rgn_d = mmd_pkg::MMD_RGN_TIMER;
			idx_d = 5'(cpu_addr - `MMD_TIMER_LO);
		end else if (cpu_addr <= `MMD_SERIAL_HI) begin
			rgn_d = mmd_pkg::MMD_RGN_SERIAL;
			idx_d = 5'(cpu_addr - `MMD_SERIAL_LO);
		end else if (cpu_addr <= `MMD_REG_TOP) begin
			rgn_d = mmd_pkg::MMD_RGN_UPPER;
			idx_d = 5'(cpu_addr - `MMD_SERIAL_LO);
		end else if (cpu_addr >= `MMD_STACK_LO && cpu_addr <= `MMD_STACK_HI) begin
			rgn_d = mmd_pkg::MMD_RGN_STACK;
		end else if (cpu_addr <= `MMD_RAM_TOP) begin
			rgn_d = mmd_pkg::MMD_RGN_RAM;
		end else if (cpu_addr >= `MMD_VEC_LO && cpu_addr <= `MMD_VEC_RES_HI) begin
			rgn_d = mmd_pkg::MMD_RGN_RSVD;
		end else if (cpu_addr >= `MMD_VEC_LO) begin
			rgn_d = mmd_pkg::MMD_RGN_VECTOR;
		end else if (cpu_addr >= `MMD_ROM_LO) begin
			rgn_d = mmd_pkg::MMD_RGN_ROM;
		end else begin
			rgn_d = mmd_pkg::MMD_RGN_RSVD;
		end
	end

	// registered decode; idle access leaves every select low
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			region_q <= 4'h0;
			reg_index_q <= 5'h00;
			ram_sel_q <= 1'b0;
			stack_sel_q <= 1'b0;
			reg_sel_q <= 1'b0;
			rom_sel_q <= 1'b0;
			rsvd_hit_q <= 1'b0;
			periph_sel_q <= 7'h00;
		end else begin
			region_q <= cpu_access ? rgn_d : mmd_pkg::MMD_RGN_NONE;
			reg_index_q <= cpu_access ? idx_d : 5'h00;
			ram_sel_q <= cpu_access && (rgn_d == mmd_pkg::MMD_RGN_RAM
				|| rgn_d == mmd_pkg::MMD_RGN_STACK);
			stack_sel_q <= cpu_access && rgn_d == mmd_pkg::MMD_RGN_STACK;
			reg_sel_q <= cpu_access && cpu_addr <= `MMD_REG_TOP
				&& rgn_d != mmd_pkg::MMD_RGN_RSVD;
			rom_sel_q <= cpu_access && (rgn_d == mmd_pkg::MMD_RGN_ROM
				|| rgn_d == mmd_pkg::MMD_RGN_VECTOR);
			// flagged for debug only; the cpu is expected never to do this
			rsvd_hit_q <= cpu_access && rgn_d == mmd_pkg::MMD_RGN_RSVD;
			periph_sel_q <= 7'h00;
			if (cpu_access) begin
				periph_sel_q[0] <= rgn_d == mmd_pkg::MMD_RGN_PORT;
				periph_sel_q[1] <= rgn_d == mmd_pkg::MMD_RGN_EXTI;
				periph_sel_q[2] <= rgn_d == mmd_pkg::MMD_RGN_MISC;
				periph_sel_q[3] <= rgn_d == mmd_pkg::MMD_RGN_CONV;
				periph_sel_q[4] <= rgn_d == mmd_pkg::MMD_RGN_WDOG;
				periph_sel_q[5] <= rgn_d == mmd_pkg::MMD_RGN_TIMER;
				periph_sel_q[6] <= rgn_d == mmd_pkg::MMD_RGN_SERIAL;
			end
		end
	end

	// vector sequencer: low byte then high byte, each held until acknowledged
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			vs_q <= mmd_pkg::MMD_VS_IDLE;
			vec_base_q <= 16'h0000;
			vec_fetch_addr_q <= 16'h0000;
			vec_fetch_valid_q <= 1'b0;
			vec_fetch_last_q <= 1'b0;
			halt_exit_q <= 1'b0;
		end else begin
			halt_exit_q <= 1'b0;
			case (vs_q)
				mmd_pkg::MMD_VS_IDLE: begin
					if (take) begin
						vs_q <= mmd_pkg::MMD_VS_LOW;
						vec_base_q <= sel_vec;
						vec_fetch_addr_q <= sel_vec;
						vec_fetch_valid_q <= 1'b1;
						vec_fetch_last_q <= 1'b0;
						halt_exit_q <= halted & sel_wake;
					end
				end
				mmd_pkg::MMD_VS_LOW: begin
					if (vec_ack) begin
						vs_q <= mmd_pkg::MMD_VS_HIGH;
						vec_fetch_addr_q <= vec_base_q | 16'h0001;
						vec_fetch_last_q <= 1'b1;
					end
				end
				mmd_pkg::MMD_VS_HIGH: begin
					if (vec_ack) begin
						vs_q <= mmd_pkg::MMD_VS_IDLE;
						vec_fetch_valid_q <= 1'b0;
						vec_fetch_last_q <= 1'b0;
					end
				end
				default: begin
					vs_q <= mmd_pkg::MMD_VS_IDLE;
					vec_fetch_valid_q <= 1'b0;
				end
			endcase
		end
	end

	// stack accesses must always land inside ram
	a_stack_in_ram: assert property (@(posedge clk_sys) disable iff (!reset_n)
		stack_sel_q |-> ram_sel_q) else $error("stack select without ram select");
	// the two fetch addresses differ only in bit 0
	a_vec_pair_order: assert property (@(posedge clk_sys) disable iff (!reset_n)
		(vs_q == mmd_pkg::MMD_VS_LOW && vec_ack) |=> (vec_fetch_last_q
		&& vec_fetch_addr_q == ($past(vec_fetch_addr_q) | 16'h0001)))
		else $error("high vector byte not after low");
	a_reset_vector: assert property (@(posedge clk_sys) disable iff (!reset_n)
		(vs_q == mmd_pkg::MMD_VS_IDLE && irq_src[0]) |=> vec_fetch_addr_q == 16'hfffe)
		else $error("reset did not fetch fffe");
	a_trap_unmasked: assert property (@(posedge clk_sys) disable iff (!reset_n)
		(vs_q == mmd_pkg::MMD_VS_IDLE && irq_src[1:0] == 2'b10 && global_mask)
		|=> (vec_fetch_valid_q && vec_fetch_addr_q == 16'hfffc && !halt_exit_q))
		else $error("trap masked or woke halt");
	a_masked_quiet: assert property (@(posedge clk_sys) disable iff (!reset_n)
		(vs_q == mmd_pkg::MMD_VS_IDLE && irq_src[1:0] == 2'b00 && global_mask)
		|=> !vec_fetch_valid_q) else $error("masked source was taken");
	a_ext_wakes: assert property (@(posedge clk_sys) disable iff (!reset_n)
		(vs_q == mmd_pkg::MMD_VS_IDLE && irq_src == 9'h010 && !global_mask && halted)
		|=> (halt_exit_q && vec_fetch_addr_q == 16'hfff6))
		else $error("external line did not wake");
	a_timer_decode: assert property (@(posedge clk_sys) disable iff (!reset_n)
		(cpu_access && cpu_addr == 16'h0019) |=> (periph_sel_q == 7'h20
		&& reg_index_q == 5'h08)) else $error("timer counter low misdecoded");
	a_serial_decode: assert property (@(posedge clk_sys) disable iff (!reset_n)
		(cpu_access && cpu_addr == 16'h0024) |=> (periph_sel_q[6] && reg_index_q == 5'h04))
		else $error("serial control two misdecoded");
	a_gap_reserved: assert property (@(posedge clk_sys) disable iff (!reset_n)
		(cpu_access && (cpu_addr == 16'h0006 || cpu_addr == 16'h000e))
		|=> (rsvd_hit_q && periph_sel_q == 7'h00)) else $error("unused address selected");
	// no access means region, peripheral selects and ram select fall back to idle
	a_idle_quiet: assert property (@(posedge clk_sys) disable iff (!reset_n)
		!cpu_access |=> (region_q == 4'h0 && periph_sel_q == 7'h00 && !ram_sel_q))
		else $error("select without access");
	// ordinary ram above the register page is never a register
	a_ram_low: assert property (@(posedge clk_sys) disable iff (!reset_n)
		(cpu_access && cpu_addr >= 16'h0040 && cpu_addr <= 16'h00ff)
		|=> (ram_sel_q && !reg_sel_q)) else $error("low ram misdecoded");
	// program memory below the vector block
	a_rom_top: assert property (@(posedge clk_sys) disable iff (!reset_n)
		(cpu_access && cpu_addr >= 16'hc000 && cpu_addr <= 16'hffdf)
		|=> (rom_sel_q && region_q == 4'hb)) else $error("program memory misdecoded");
	// port pairs pass the raw offset so data and direction stay apart
	a_port_decode: assert property (@(posedge clk_sys) disable iff (!reset_n)
		(cpu_access && cpu_addr <= 16'h0005) |=> (periph_sel_q == 7'h01
		&& reg_index_q == $past(cpu_addr[4:0]))) else $error("port misdecoded");
	// the wake pulse never lasts past one cycle
	a_halt_pulse: assert property (@(posedge clk_sys) disable iff (!reset_n)
		halt_exit_q |=> !halt_exit_q) else $error("halt exit held too long");
	// programming start may end halt
	a_prog_wakes: assert property (@(posedge clk_sys) disable iff (!reset_n)
		(vs_q == mmd_pkg::MMD_VS_IDLE && irq_src == 9'h004 && !global_mask && halted)
		|=> (halt_exit_q && vec_fetch_addr_q == 16'hfffa))
		else $error("programming start did not wake");
	// end of suspend may end halt
	a_resume_wakes: assert property (@(posedge clk_sys) disable iff (!reset_n)
		(vs_q == mmd_pkg::MMD_VS_IDLE && irq_src == 9'h008 && !global_mask && halted)
		|=> (halt_exit_q && vec_fetch_addr_q == 16'hfff8))
		else $error("resume did not wake");
	// internal sources vector but stay asleep
	a_timer_no_wake: assert property (@(posedge clk_sys) disable iff (!reset_n)
		(vs_q == mmd_pkg::MMD_VS_IDLE && irq_src == 9'h020 && !global_mask && halted)
		|=> (!halt_exit_q && vec_fetch_addr_q == 16'hfff4))
		else $error("timer woke halt");
endmodule

// ===== mmd_cpu_model.sv
// behavioural cpu core that takes the vector bytes offered by the decoder
`timescale 1ns/1ps
module mmd_cpu_model (
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic [3:0] slow,
	input wire logic [15:0] vec_fetch_addr_q,
	input wire logic vec_fetch_valid_q,
	output logic vec_ack,
	output logic [15:0] prev_addr,
	output logic [15:0] last_addr,
	output logic [7:0] byte_cnt
);
	logic [3:0] wait_q;
	// ack each offered byte after a stall; only offered vector bytes are fetched
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			vec_ack <= 1'b0;
			wait_q <= 4'h0;
			prev_addr <= 16'h0000;
			last_addr <= 16'h0000;
			byte_cnt <= 8'h00;
		end else if (vec_ack) begin
			vec_ack <= 1'b0; // one edge per byte, so a byte is never taken twice
			prev_addr <= last_addr;
			last_addr <= vec_fetch_addr_q;
			byte_cnt <= byte_cnt + 8'h01;
			wait_q <= 4'h0;
		end else if (vec_fetch_valid_q) begin
			if (wait_q >= slow) begin
				vec_ack <= 1'b1;
			end else begin
				wait_q <= wait_q + 4'h1;
			end
		end
	end
endmodule

// ===== mmd_decoder_bench.sv
// self-checking bench for the memory map decoder
`timescale 1ns/1ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin fails++; \
	$display("unexpected at %0t: got %h expected %h", $time, a, b); end end
module mmd_decoder_bench;
	logic clk_sys = 1'b0;
	logic reset_n = 1'b0;
	logic [15:0] cpu_addr = 16'h0000;
	logic cpu_access = 1'b0;
	logic [8:0] irq_src = 9'h000;
	logic global_mask = 1'b0;
	logic halted = 1'b0;
	logic [3:0] slow = 4'h0;
	logic vec_ack;
	logic [3:0] region_q;
	logic [4:0] reg_index_q;
	logic ram_sel_q, stack_sel_q, reg_sel_q, rom_sel_q, rsvd_hit_q;
	logic [6:0] periph_sel_q;
	logic [15:0] vec_fetch_addr_q, prev_addr, last_addr;
	logic vec_fetch_valid_q, vec_fetch_last_q, halt_exit_q;
	logic [7:0] byte_cnt;
	int fails = 0;
	int total_checks = 0;
	logic [15:0] vtab [9] = '{16'hfffe, 16'hfffc, 16'hfffa, 16'hfff8, 16'hfff6,
		16'hfff4, 16'hfff2, 16'hfff0, 16'hffee};
	logic [8:0] wake_set = 9'h01d; // reset, programming, resume, external lines
	always #2.5 clk_sys = ~clk_sys;
	mmd_decoder u_mmd_decoder (.clk_sys(clk_sys), .reset_n(reset_n), .cpu_addr(cpu_addr),
		.cpu_access(cpu_access), .irq_src(irq_src), .global_mask(global_mask),
		.halted(halted), .vec_ack(vec_ack), .region_q(region_q), .reg_index_q(reg_index_q),
		.ram_sel_q(ram_sel_q), .stack_sel_q(stack_sel_q), .reg_sel_q(reg_sel_q),
		.rom_sel_q(rom_sel_q), .rsvd_hit_q(rsvd_hit_q), .periph_sel_q(periph_sel_q),
		.vec_fetch_addr_q(vec_fetch_addr_q), .vec_fetch_valid_q(vec_fetch_valid_q),
		.vec_fetch_last_q(vec_fetch_last_q), .halt_exit_q(halt_exit_q));
	mmd_cpu_model u_mmd_cpu_model (.clk_sys(clk_sys), .reset_n(reset_n), .slow(slow),
		.vec_fetch_addr_q(vec_fetch_addr_q), .vec_fetch_valid_q(vec_fetch_valid_q),
		.vec_ack(vec_ack), .prev_addr(prev_addr), .last_addr(last_addr), .byte_cnt(byte_cnt));
	task automatic conclude();
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	// one access, judged one cycle later; idx 1f means no offset check
	task automatic dec(input logic [15:0] a, input logic [3:0] rgn, input logic [6:0] per,
		input logic [4:0] idx);
		@(posedge clk_sys);
		cpu_addr <= a;
		cpu_access <= 1'b1;
		@(posedge clk_sys);
		#1;
		`CHK(region_q, rgn)
		`CHK(periph_sel_q, per)
		`CHK(rsvd_hit_q, rgn == mmd_pkg::MMD_RGN_RSVD)
		`CHK(stack_sel_q, rgn == mmd_pkg::MMD_RGN_STACK)
		`CHK(reg_sel_q, a <= 16'h003f && rgn != mmd_pkg::MMD_RGN_RSVD)
		if (rgn == mmd_pkg::MMD_RGN_ROM) `CHK(rom_sel_q, 1'b1)
		if (idx != 5'h1f) `CHK(reg_index_q, idx)
	endtask
	// raise a request, expect its vector pair low byte first
	task automatic vec(input logic [8:0] src, input logic msk, input logic hlt,
		input logic [15:0] ea, input logic ew);
		int n;
		logic [7:0] b0;
		b0 = byte_cnt;
		@(posedge clk_sys);
		irq_src <= src;
		global_mask <= msk;
		halted <= hlt;
		for (n = 0; n < 20 && vec_fetch_valid_q !== 1'b1; n++) begin
			@(posedge clk_sys);
			#1;
		end
		`CHK(vec_fetch_valid_q, 1'b1)
		`CHK(halt_exit_q, ew & hlt)
		@(posedge clk_sys);
		irq_src <= 9'h000;
		for (n = 0; n < 60 && byte_cnt !== b0 + 8'h02; n++) @(posedge clk_sys);
		#1;
		`CHK(prev_addr, ea)
		`CHK(last_addr, ea | 16'h0001)
		`CHK(vec_fetch_valid_q, 1'b0)
	endtask
	initial begin
		int i;
		repeat (16) @(posedge clk_sys);
		#1;
		`CHK(vec_fetch_valid_q, 1'b0)
		@(posedge clk_sys);
		reset_n <= 1'b1;
		// decode of each low page block but the upper register page, some of their edges, and the memories
		dec(16'h0000, mmd_pkg::MMD_RGN_PORT, 7'h01, 5'h00);
		dec(16'h0005, mmd_pkg::MMD_RGN_PORT, 7'h01, 5'h05);
		dec(16'h0006, mmd_pkg::MMD_RGN_RSVD, 7'h00, 5'h1f);
		dec(16'h0008, mmd_pkg::MMD_RGN_EXTI, 7'h02, 5'h1f);
		dec(16'h0009, mmd_pkg::MMD_RGN_MISC, 7'h04, 5'h1f);
		dec(16'h000b, mmd_pkg::MMD_RGN_CONV, 7'h08, 5'h01);
		dec(16'h000c, mmd_pkg::MMD_RGN_WDOG, 7'h10, 5'h1f);
		dec(16'h000e, mmd_pkg::MMD_RGN_RSVD, 7'h00, 5'h1f);
		dec(16'h0010, mmd_pkg::MMD_RGN_RSVD, 7'h00, 5'h1f);
		dec(16'h0019, mmd_pkg::MMD_RGN_TIMER, 7'h20, 5'h08);
		dec(16'h0011, mmd_pkg::MMD_RGN_TIMER, 7'h20, 5'h00);
		dec(16'h001f, mmd_pkg::MMD_RGN_TIMER, 7'h20, 5'h0e);
		dec(16'h0024, mmd_pkg::MMD_RGN_SERIAL, 7'h40, 5'h04);
		dec(16'h0040, mmd_pkg::MMD_RGN_RAM, 7'h00, 5'h1f);
		dec(16'h0100, mmd_pkg::MMD_RGN_STACK, 7'h00, 5'h1f);
		dec(16'h017f, mmd_pkg::MMD_RGN_STACK, 7'h00, 5'h1f);
		dec(16'h0180, mmd_pkg::MMD_RGN_RAM, 7'h00, 5'h1f);
		dec(16'h01ff, mmd_pkg::MMD_RGN_RAM, 7'h00, 5'h1f);
		dec(16'h0200, mmd_pkg::MMD_RGN_RSVD, 7'h00, 5'h1f);
		dec(16'hc000, mmd_pkg::MMD_RGN_ROM, 7'h00, 5'h1f);
		dec(16'hffdf, mmd_pkg::MMD_RGN_ROM, 7'h00, 5'h1f);
		dec(16'hffed, mmd_pkg::MMD_RGN_RSVD, 7'h00, 5'h1f);
		dec(16'hffee, mmd_pkg::MMD_RGN_VECTOR, 7'h00, 5'h1f);
		@(posedge clk_sys);
		cpu_access <= 1'b0;
		@(posedge clk_sys);
		#1;
		`CHK(region_q, 4'h0)
		$display("test decode done");
		// every source alone, woken from halt where it may
		for (i = 0; i < 9; i++) vec(9'h001 << i, 1'b0, 1'b1, vtab[i], wake_set[i]);
		$display("test vectors done");
		@(posedge clk_sys);
		// priority and masking with a slow cpu
		slow <= 4'h3;
		vec(9'h1ff, 1'b1, 1'b1, 16'hfffe, 1'b1);
		vec(9'h1fe, 1'b1, 1'b1, 16'hfffc, 1'b0);
		vec(9'h1f0, 1'b0, 1'b1, 16'hfff6, 1'b1);
		vec(9'h001, 1'b0, 1'b0, 16'hfffe, 1'b0);
		@(posedge clk_sys);
		irq_src <= 9'h1fc;
		global_mask <= 1'b1;
		repeat (10) @(posedge clk_sys);
		#1;
		`CHK(vec_fetch_valid_q, 1'b0)
		$display("test priority done");
		@(posedge clk_sys);
		// reset in mid fetch clears fetch valid, halt exit and fetch address at once
		global_mask <= 1'b0;
		repeat (3) @(posedge clk_sys);
		reset_n <= 1'b0;
		#1;
		`CHK({vec_fetch_valid_q, halt_exit_q, vec_fetch_addr_q}, 18'h00000)
		@(posedge clk_sys);
		irq_src <= 9'h000;
		@(posedge clk_sys);
		reset_n <= 1'b1;
		vec(9'h010, 1'b0, 1'b1, 16'hfff6, 1'b1);
		$display("test reset done");
		conclude();
	end
	// watchdog well beyond the few hundred cycles the tests need
	initial begin
		#200000;
		fails++;
		conclude();
	end
endmodule
